// *** hw/fbd_pkg.sv ***
// Shared constants and types for the flash boot decode block and its bus agent.
package fbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Local bus transfer sizes.
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } fbd_size_t;

  ////////////////////////////////////////////////////////////////////////////
  // Address windows, each given by its base and the log2 of its size, then the two lockout register addresses and the vector mask.
  localparam logic [31:0] ONB_BASE    = 32'hFC00_0000;
  localparam int unsigned ONB_BITS    = 23;
  localparam logic [31:0] MOD_BASE    = 32'hFD00_0000;
  localparam int unsigned MOD_BITS    = 24;
  localparam logic [31:0] LEG_BASE    = 32'hFE40_0000;
  localparam logic [31:0] SK0_BASE    = 32'hFE00_0000;
  localparam int unsigned ROM_BITS    = 20;
  localparam logic [31:0] LOCK_STAT   = 32'hFE3A_0006;
  localparam logic [31:0] LOCK_SET    = 32'hFE3A_0007;
  localparam logic [31:0] VEC_MASK    = 32'h000F_FFFF;

  // Erase block sizes as log2 of bytes.
  localparam int unsigned MOD_BLK_BITS = 16;
  localparam int unsigned ONB_BLK_BITS = 18;

  // Byte lane enables of the 32-bit onboard path.
  localparam logic [3:0] LANE_ONE = 4'h1;
  localparam logic [3:0] LANE_LO  = 4'h3;
  localparam logic [3:0] LANE_HI  = 4'hC;
  localparam logic [3:0] LANE_ALL = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Jumper vector layout inside the device.
  localparam int unsigned JP_W     = 5;
  localparam int unsigned JP_WREN  = 0;
  localparam int unsigned JP_FBOOT = 1;
  localparam int unsigned JP_TYPE0 = 2;
  localparam int unsigned JP_TYPE1 = 3;
  localparam int unsigned JP_MOD   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned CLK_NS   = 50;
  localparam int unsigned ACC_NS   = 150;
  localparam int unsigned ACC_CYC  = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  ACC_LOAD = 2'(ACC_CYC - 1);
  localparam int unsigned TMO_US   = 4000;
  localparam int unsigned TMO_CYC  = TMO_US * 1000 / CLK_NS;
  localparam int unsigned TMO_W    = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Agent register offsets (byte addresses) and field positions.
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_BLK   = 8'h14;
  localparam logic [7:0] REG_BADDR = 8'h18;

  localparam int unsigned CMD_GO  = 0;
  localparam int unsigned CMD_WE  = 1;
  localparam int unsigned CMD_SZ  = 2;
  localparam int unsigned CMD_CPU = 4;
  localparam int unsigned CMD_VEC = 5;

  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_TMO  = 2;
  localparam int unsigned ST_REF  = 3;

  localparam int unsigned BLK_ONB = 8;

endpackage : fbd_pkg

// *** hw/fbd_lbus_if.sv ***
// Local bus between the processor-side agent and the flash decode device.
`timescale 1ns/1ps
interface fbd_lbus_if;
  logic        req;
  logic        we;
  logic [1:0]  size;
  logic        cpu_id;
  logic        vec;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;

  modport dev (
    input  req, we, size, cpu_id, vec, addr, wdata,
    output ack, rdata
  );

  modport cpu (
    output req, we, size, cpu_id, vec, addr, wdata,
    input  ack, rdata
  );
endinterface : fbd_lbus_if

// *** hw/fbd_dev.sv ***
// Flash and boot ROM address decode, write gate and lockout device.
`timescale 1ns/1ps
module fbd_dev (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  fbd_lbus_if.dev          lbus,
  input  wire logic [1:0]  flash_write_boot_jumper_i,
  input  wire logic [1:0]  rom_type_select_jumper_i,
  input  wire logic        module_present_i,
  output logic             module_cs_o,
  output logic             boot_rom_socket_zero_cs_o,
  output logic             boot_rom_socket_one_cs_o,
  output logic             onboard_cs_o,
  output logic             mem_oe_o,
  output logic             mem_we_o,
  output logic [3:0]       mem_lane_o,
  output logic [23:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  input  wire logic [31:0] mem_rdata_i,
  output logic             lockout_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef enum logic [1:0] {
    DS_IDLE,
    DS_ACC,
    DS_ACK
  } fbd_dst_t;

  typedef struct packed {
    logic [fbd_pkg::JP_W-1:0] s1;
    logic [fbd_pkg::JP_W-1:0] s2;
    logic [fbd_pkg::JP_W-1:0] s3;
    logic [fbd_pkg::JP_W-1:0] jp;
    fbd_dst_t                 st;
    logic [1:0]               cnt;
    logic                     lock;
    logic                     wide;
    logic [31:0]              rdata;
    logic                     mod_cs;
    logic                     sk0_cs;
    logic                     sk1_cs;
    logic                     onb_cs;
    logic                     oe;
    logic                     we;
    logic [3:0]               lane;
    logic [23:0]              maddr;
    logic [31:0]              wdata;
  } fbd_dev_t;

  fbd_dev_t state_ff;
  fbd_dev_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic in_win(input logic [31:0] a,
                                  input logic [31:0] base,
                                  input int unsigned bits);
    in_win = (a >> bits) == (base >> bits);
  endfunction : in_win

  function automatic logic [3:0] lane_en(input logic [1:0] sz,
                                         input logic [1:0] a);
    case (sz)
      fbd_pkg::SZ_BYTE: lane_en = fbd_pkg::LANE_ONE << a;
      fbd_pkg::SZ_WORD: lane_en = a[1] ? fbd_pkg::LANE_HI : fbd_pkg::LANE_LO;
      default:          lane_en = fbd_pkg::LANE_ALL;
    endcase
  endfunction : lane_en

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  logic [fbd_pkg::JP_W-1:0] jp_pins;
  logic [31:0]              ea;
  logic [31:0]              vec_base;
  logic                     hit_onb;
  logic                     hit_mod;
  logic                     hit_leg;
  logic                     hit_sk0;
  logic                     hit_stat;
  logic                     hit_set;
  logic                     sock_wr_ok;
  logic                     sk1_flash;
  logic                     held;

  always_comb begin
    jp_pins = {module_present_i, rom_type_select_jumper_i,
               flash_write_boot_jumper_i};
    nxt_state = state_ff;

    // Jumpers are static straps from off-chip; a new value is accepted only
    // once the second and third stages agree, so a bouncing jumper never
    // flips the decode halfway through an access.
    nxt_state.s1 = jp_pins;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    nxt_state.jp = (~(state_ff.s2 ^ state_ff.s3) & state_ff.s3) |
                   ((state_ff.s2 ^ state_ff.s3) & state_ff.jp);

    // Vector fetches keep only the offset inside a ROM-sized window.
    if (state_ff.jp[fbd_pkg::JP_FBOOT]) begin
      vec_base = fbd_pkg::ONB_BASE;
    end else if (lbus.cpu_id) begin
      vec_base = fbd_pkg::MOD_BASE;
    end else begin
      vec_base = fbd_pkg::SK0_BASE;
    end
    ea = lbus.vec ? (vec_base | (lbus.addr & fbd_pkg::VEC_MASK)) : lbus.addr;

    hit_onb  = in_win(ea, fbd_pkg::ONB_BASE, fbd_pkg::ONB_BITS);
    hit_mod  = in_win(ea, fbd_pkg::MOD_BASE, fbd_pkg::MOD_BITS);
    hit_leg  = in_win(ea, fbd_pkg::LEG_BASE, fbd_pkg::ROM_BITS);
    hit_sk0  = in_win(ea, fbd_pkg::SK0_BASE, fbd_pkg::ROM_BITS);
    hit_stat = ea == fbd_pkg::LOCK_STAT;
    hit_set  = ea == fbd_pkg::LOCK_SET;

    // Socket one holds the module when one is fitted, so its type jumper
    // governs both the module and a plain device in the socket.
    sk1_flash = state_ff.jp[fbd_pkg::JP_TYPE1];
    if (hit_sk0) begin
      sock_wr_ok = state_ff.jp[fbd_pkg::JP_TYPE0] &&
                   state_ff.jp[fbd_pkg::JP_WREN];
    end else if (hit_mod || hit_leg) begin
      sock_wr_ok = sk1_flash && state_ff.jp[fbd_pkg::JP_WREN];
    end else begin
      // The onboard strobe shares the socket zero programming line, so it
      // is only free when socket zero is strapped as plain ROM.
      sock_wr_ok = !state_ff.jp[fbd_pkg::JP_TYPE0];
    end

    held = lbus.cpu_id && state_ff.lock && (hit_mod || hit_leg);

    case (state_ff.st)
      DS_IDLE: begin
        if (lbus.req && !held) begin
          nxt_state.maddr = ea[23:0];
          nxt_state.wdata = lbus.wdata;
          nxt_state.cnt   = fbd_pkg::ACC_LOAD;
          nxt_state.rdata = '0;
          nxt_state.wide  = hit_onb;
          if (hit_onb || hit_mod || hit_leg || hit_sk0) begin
            nxt_state.st     = DS_ACC;
            nxt_state.onb_cs = hit_onb;
            nxt_state.mod_cs = hit_mod &&
                               state_ff.jp[fbd_pkg::JP_MOD];
            nxt_state.sk1_cs = hit_leg || (hit_mod &&
                               !state_ff.jp[fbd_pkg::JP_MOD]);
            nxt_state.sk0_cs = hit_sk0;
            nxt_state.we     = lbus.we && sock_wr_ok;
            nxt_state.oe     = !lbus.we;
            nxt_state.lane   = hit_onb ? lane_en(lbus.size, ea[1:0])
                                       : fbd_pkg::LANE_ONE;
          end else begin
            nxt_state.st = DS_ACK;
            if (hit_set && lbus.we) begin
              nxt_state.lock = 1'b1;
            end
            if (hit_stat && !lbus.we) begin
              nxt_state.rdata = {31'h0000_0000, !state_ff.lock};
            end
          end
        end
      end
      DS_ACC: begin
        if (state_ff.cnt == '0) begin
          nxt_state.rdata  = state_ff.wide ? mem_rdata_i
                             : {24'h00_0000, mem_rdata_i[7:0]};
          nxt_state.onb_cs = 1'b0;
          nxt_state.mod_cs = 1'b0;
          nxt_state.sk0_cs = 1'b0;
          nxt_state.sk1_cs = 1'b0;
          nxt_state.we     = 1'b0;
          nxt_state.oe     = 1'b0;
          nxt_state.st     = DS_ACK;
        end else begin
          nxt_state.cnt = state_ff.cnt - 2'h1;
        end
      end
      DS_ACK: begin
        nxt_state.st = DS_IDLE;
      end
      default: begin
        nxt_state.st = DS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register. Reset clears the lockout and disables every strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign lbus.ack                  = state_ff.st == DS_ACK;
  assign lbus.rdata                = state_ff.rdata;
  assign module_cs_o               = state_ff.mod_cs;
  assign boot_rom_socket_zero_cs_o = state_ff.sk0_cs;
  assign boot_rom_socket_one_cs_o  = state_ff.sk1_cs;
  assign onboard_cs_o              = state_ff.onb_cs;
  assign mem_oe_o                  = state_ff.oe;
  assign mem_we_o                  = state_ff.we;
  assign mem_lane_o                = state_ff.lane;
  assign mem_addr_o                = state_ff.maddr;
  assign mem_wdata_o               = state_ff.wdata;
  assign lockout_o                 = state_ff.lock;

endmodule : fbd_dev

// *** hw/fbd_cpu.sv ***
// Processor-side agent: Wishbone registers that issue local bus transfers.
`timescale 1ns/1ps
module fbd_cpu #(
  parameter int unsigned TMO_CYC = fbd_pkg::TMO_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  fbd_lbus_if.cpu          lbus
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef enum logic {
    HS_IDLE,
    HS_WAIT
  } fbd_hst_t;

  typedef struct packed {
    fbd_hst_t                  st;
    logic                      wack;
    logic [31:0]               wdat;
    logic [5:0]                cmd;
    logic [31:0]               addr;
    logic [31:0]               wdata;
    logic [31:0]               rdata;
    logic                      done;
    logic                      tmo;
    logic                      refused;
    logic [8:0]                blk;
    logic [fbd_pkg::TMO_W-1:0] cnt;
    logic                      req;
  } fbd_cpu_t;

  fbd_cpu_t state_ff;
  fbd_cpu_t nxt_state;

  localparam logic [fbd_pkg::TMO_W-1:0] TMO_LAST =
    fbd_pkg::TMO_W'(TMO_CYC - 1);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? val[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  function automatic logic [31:0] blk_addr(input logic [8:0] b);
    if (b[fbd_pkg::BLK_ONB]) begin
      blk_addr = fbd_pkg::ONB_BASE |
                 (32'(b[7:0]) << fbd_pkg::ONB_BLK_BITS);
    end else begin
      blk_addr = fbd_pkg::MOD_BASE |
                 (32'(b[7:0]) << fbd_pkg::MOD_BLK_BITS);
    end
  endfunction : blk_addr

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  logic        wr;
  logic        rd;
  logic        narrow;
  logic [31:0] cmd_w;
  logic [31:0] rmux;

  always_comb begin
    nxt_state = state_ff;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !state_ff.wack;
    rd = wb_cyc_i && wb_stb_i && !wb_we_i && !state_ff.wack;
    nxt_state.wack = wb_cyc_i && wb_stb_i && !state_ff.wack;
    cmd_w = merge({26'h000_0000, state_ff.cmd}, wb_dat_i, wb_sel_i);
    narrow = (cmd_w[fbd_pkg::CMD_SZ +: 2] != fbd_pkg::SZ_BYTE) &&
             ((state_ff.addr >> fbd_pkg::MOD_BITS) ==
              (fbd_pkg::MOD_BASE >> fbd_pkg::MOD_BITS));

    case (wb_adr_i)
      fbd_pkg::REG_CMD:   rmux = {26'h000_0000, state_ff.cmd};
      fbd_pkg::REG_ADDR:  rmux = state_ff.addr;
      fbd_pkg::REG_WDATA: rmux = state_ff.wdata;
      fbd_pkg::REG_RDATA: rmux = state_ff.rdata;
      fbd_pkg::REG_STAT:  rmux = {28'h000_0000, state_ff.refused,
                                  state_ff.tmo, state_ff.done,
                                  state_ff.st == HS_WAIT};
      fbd_pkg::REG_BLK:   rmux = {23'h00_0000, state_ff.blk};
      fbd_pkg::REG_BADDR: rmux = blk_addr(state_ff.blk);
      default:            rmux = '0;
    endcase
    if (rd) begin
      nxt_state.wdat = rmux;
    end

    // Status bits clear by writing one; a same-cycle event still sets them.
    if (wr && wb_adr_i == fbd_pkg::REG_STAT && wb_sel_i[0]) begin
      nxt_state.done    = state_ff.done && !wb_dat_i[fbd_pkg::ST_DONE];
      nxt_state.tmo     = state_ff.tmo && !wb_dat_i[fbd_pkg::ST_TMO];
      nxt_state.refused = state_ff.refused && !wb_dat_i[fbd_pkg::ST_REF];
    end
    // Request fields are frozen while a transfer is in flight.
    if (wr && state_ff.st == HS_IDLE) begin
      case (wb_adr_i)
        fbd_pkg::REG_ADDR:  nxt_state.addr  =
                              merge(state_ff.addr, wb_dat_i, wb_sel_i);
        fbd_pkg::REG_WDATA: nxt_state.wdata =
                              merge(state_ff.wdata, wb_dat_i, wb_sel_i);
        fbd_pkg::REG_BLK:   nxt_state.blk   =
                              9'(merge({23'h00_0000, state_ff.blk}, wb_dat_i,
                                       wb_sel_i));
        default: ;
      endcase
    end

    case (state_ff.st)
      HS_IDLE: begin
        if (wr && wb_adr_i == fbd_pkg::REG_CMD) begin
          nxt_state.cmd = {cmd_w[5:1], 1'b0};
          if (cmd_w[fbd_pkg::CMD_GO]) begin
            if (narrow) begin
              nxt_state.refused = 1'b1;
            end else begin
              nxt_state.req = 1'b1;
              nxt_state.cnt = '0;
              nxt_state.st  = HS_WAIT;
            end
          end
        end
      end
      HS_WAIT: begin
        if (lbus.ack) begin
          nxt_state.rdata = lbus.rdata;
          nxt_state.req   = 1'b0;
          nxt_state.done  = 1'b1;
          nxt_state.st    = HS_IDLE;
        end else if (state_ff.cnt == TMO_LAST) begin
          nxt_state.req = 1'b0;
          nxt_state.tmo = 1'b1;
          nxt_state.st  = HS_IDLE;
        end else begin
          nxt_state.cnt = state_ff.cnt + 1'b1;
        end
      end
      default: begin
        nxt_state.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign wb_ack_o    = state_ff.wack;
  assign wb_dat_o    = state_ff.wdat;
  assign lbus.req    = state_ff.req;
  assign lbus.we     = state_ff.cmd[fbd_pkg::CMD_WE];
  assign lbus.size   = state_ff.cmd[fbd_pkg::CMD_SZ +: 2];
  assign lbus.cpu_id = state_ff.cmd[fbd_pkg::CMD_CPU];
  assign lbus.vec    = state_ff.cmd[fbd_pkg::CMD_VEC];
  assign lbus.addr   = state_ff.addr;
  assign lbus.wdata  = state_ff.wdata;

endmodule : fbd_cpu

// *** dv/fbd_sva.sv ***
// Local bus assertions for the agent and decode device pair.
`timescale 1ns/1ps
module fbd_sva (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [1:0]  size,
  input  wire logic        cpu_id,
  input  wire logic        vec,
  input  wire logic [31:0] addr,
  input  wire logic        ack,
  input  wire logic [31:0] rdata
);
  // Lockout shadow; only a reset clears it, exactly as in the device.
  logic locked_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_ff <= 1'b0;
    end else if (ack && we && addr == fbd_pkg::LOCK_SET) begin
      locked_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  byte_only_a: assert property (req && addr[31:24] == 8'hFD && !vec
    |-> size == fbd_pkg::SZ_BYTE) else $error("module access not byte wide");
  module_answer_a: assert property (
    $rose(req) && addr[31:24] == 8'hFD && !cpu_id |-> ##[2:7] ack)
    else $error("module window access not answered");
  legacy_answer_a: assert property (
    $rose(req) && addr[31:20] == 12'hFE4 && !cpu_id |-> ##[2:7] ack)
    else $error("legacy window access not answered");
  onboard_answer_a: assert property (
    $rose(req) && addr[31:23] == 9'h1F8 |-> ##[2:7] ack)
    else $error("onboard access not answered");
  vec_answer_a: assert property (
    $rose(req) && vec && !cpu_id |-> ##[2:7] ack)
    else $error("vector fetch not answered");
  lock_answer_a: assert property (
    $rose(req) && we && addr == fbd_pkg::LOCK_SET |-> ##[1:2] ack)
    else $error("lockout write not answered");
  lock_status_a: assert property (
    ack && !we && addr == fbd_pkg::LOCK_STAT
    |-> rdata[7:0] == {7'h0, !locked_ff})
    else $error("lockout status byte wrong");
  held_off_a: assert property (req && cpu_id && locked_ff &&
    (addr[31:20] == 12'hFE4 || addr[31:24] == 8'hFD) |-> !ack)
    else $error("locked out access completed");
  cover property (ack && we && addr == fbd_pkg::LOCK_SET);
  cover property (req && cpu_id && locked_ff);
  cover property (ack && vec);
endmodule : fbd_sva

// *** dv/fbd_tb_top.sv ***
// Bench that joins the agent and the decode device and checks both.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
$display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module fbd_tb_top;
  logic        clk_i, rst_i, cyc, we, ack, lock, mp, mcs, zcs, ocs, bcs;
  logic        mwe, oe, s_we, s_oe, clr;
  logic [1:0]  fj, tj;
  logic [3:0]  lane, s_cs, s_ln;
  logic [7:0]  adr, s_wd;
  logic [23:0] maddr;
  logic [31:0] dat, dat_o, mrd, mwd;
  int          mismatches, n_checks;
  fbd_lbus_if u_fbd_lbus_if ();
  fbd_cpu #(.TMO_CYC(50)) u_fbd_cpu (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .lbus(u_fbd_lbus_if));
  fbd_dev u_fbd_dev (
    .clk_i(clk_i), .rst_i(rst_i), .lbus(u_fbd_lbus_if),
    .flash_write_boot_jumper_i(fj), .rom_type_select_jumper_i(tj),
    .module_present_i(mp), .module_cs_o(mcs),
    .boot_rom_socket_zero_cs_o(zcs), .boot_rom_socket_one_cs_o(ocs),
    .onboard_cs_o(bcs), .mem_oe_o(oe), .mem_we_o(mwe), .mem_lane_o(lane),
    .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_rdata_i(mrd),
    .lockout_o(lock));
  fbd_sva u_fbd_sva (
    .clk_i(clk_i), .rst_i(rst_i), .req(u_fbd_lbus_if.req),
    .we(u_fbd_lbus_if.we), .size(u_fbd_lbus_if.size),
    .cpu_id(u_fbd_lbus_if.cpu_id), .vec(u_fbd_lbus_if.vec),
    .addr(u_fbd_lbus_if.addr), .ack(u_fbd_lbus_if.ack),
    .rdata(u_fbd_lbus_if.rdata));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Read data echoes the address, so a wrong window or lane shows up.
  always @(posedge clk_i) begin
    mrd <= {8'hC3, maddr};
    if (clr) begin
      {s_cs, s_ln, s_we, s_oe, s_wd} <= '0;
    end else begin
      if (mcs | zcs | ocs | bcs) begin
        s_cs <= {mcs, zcs, ocs, bcs};
        s_ln <= lane;
        s_oe <= oe;
      end
      if (mwe) begin
        s_we <= 1'b1;
        s_wd <= mwd[7:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    {cyc, we, adr, dat} <= {1'b1, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic op(input logic [5:0] c, input logic [31:0] a, d,
                    output logic [31:0] st, r);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wb(1'b1, fbd_pkg::REG_STAT, 32'hE, r);
    wb(1'b1, fbd_pkg::REG_ADDR, a, r);
    wb(1'b1, fbd_pkg::REG_WDATA, d, r);
    wb(1'b1, fbd_pkg::REG_CMD, {26'h0, c}, r);
    st = 32'h0;
    while (st[3:1] === 3'h0) wb(1'b0, fbd_pkg::REG_STAT, 32'h0, st);
    wb(1'b0, fbd_pkg::REG_RDATA, 32'h0, r);
  endtask : op
  // Jumpers pass a filter, so let them settle before the next access.
  task automatic jp(input logic [1:0] f, t, input logic m);
    {fj, tj, mp} <= {f, t, m};
    repeat (6) @(posedge clk_i);
  endtask : jp
  task automatic rst_pulse(input int n);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : rst_pulse
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_decode();
    logic [31:0] st, r, a;
    logic [5:0]  c;
    logic [1:0]  f;
    logic        m;
    logic [3:0]  ecs, eln;
    logic [48:0] rows [9] = '{{32'hFC000000, 6'h09, 2'h0, 1'b1, 8'h1F},
      {32'hFC000003, 6'h01, 2'h0, 1'b1, 8'h18},
      {32'hFD000010, 6'h01, 2'h0, 1'b1, 8'h81},
      {32'hFD000010, 6'h01, 2'h0, 1'b0, 8'h21},
      {32'hFE400020, 6'h01, 2'h0, 1'b1, 8'h21},
      {32'hFE000030, 6'h01, 2'h0, 1'b1, 8'h41},
      {32'h00000000, 6'h21, 2'h2, 1'b0, 8'h11},
      {32'h00000000, 6'h21, 2'h0, 1'b0, 8'h41},
      {32'h00000000, 6'h31, 2'h0, 1'b0, 8'h21}};
    for (int i = 0; i < 9; i++) begin
      {a, c, f, m, ecs, eln} = rows[i];
      jp(f, 2'h0, m);
      op(c, a, 32'h0, st, r);
      `CHK(s_cs, ecs)
      `CHK(s_ln, eln)
      `CHK(s_oe, 1'b1)
      if (i == 0) `CHK(r, 32'hC3000000)
      if (i != 1) `CHK(r[7:0], a[7:0])
    end
    $display("test decode done");
  endtask : t_decode
  task automatic t_gate();
    logic [31:0] st, r;
    logic [36:0] rows [7] = '{{32'hFE000000, 5'h0B}, {32'hFE000000, 5'h02},
      {32'hFE000000, 5'h08}, {32'hFD000000, 5'h0D}, {32'hFD000000, 5'h04},
      {32'hFC000000, 5'h01}, {32'hFC000000, 5'h0A}};
    for (int i = 0; i < 7; i++) begin
      jp(rows[i][4:3], rows[i][2:1], 1'b1);
      op(6'h03, rows[i][36:5], 32'h5A, st, r);
      `CHK(st[3:0], 4'h2)
      `CHK(s_we, rows[i][0])
      `CHK({s_oe, s_wd}, {1'b0, rows[i][0] ? 8'h5A : 8'h00})
    end
    $display("test write gate done");
  endtask : t_gate
  task automatic t_regs();
    logic [31:0] st, r;
    logic [40:0] rows [4] = '{{9'h003, 32'hFD030000},
      {9'h0FF, 32'hFDFF0000}, {9'h105, 32'hFC140000},
      {9'h11F, 32'hFC7C0000}};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, fbd_pkg::REG_BLK, {23'h0, rows[i][40:32]}, r);
      wb(1'b0, fbd_pkg::REG_BADDR, 32'h0, r);
      `CHK(r, rows[i][31:0])
    end
    wb(1'b1, 8'h1C, 32'hFFFFFFFF, r);
    wb(1'b0, 8'h1C, 32'h0, r);
    `CHK(r, 32'h0)
    op(6'h07, 32'hFD000000, 32'h0, st, r);
    `CHK({st[3], s_cs}, 5'h10)
    $display("test registers done");
  endtask : t_regs
  task automatic t_lock();
    logic [31:0] st, r;
    jp(2'h0, 2'h0, 1'b0);
    op(6'h01, fbd_pkg::LOCK_STAT, 32'h0, st, r);
    `CHK(r[7:0], 8'h01)
    op(6'h03, fbd_pkg::LOCK_SET, 32'h1, st, r);
    `CHK(lock, 1'b1)
    op(6'h01, fbd_pkg::LOCK_STAT, 32'h0, st, r);
    `CHK(r[7:0], 8'h00)
    op(6'h11, 32'hFE400000, 32'h0, st, r);
    `CHK({st[2], s_cs}, 5'h10)
    op(6'h01, 32'hFE400000, 32'h0, st, r);
    `CHK({st[3:0], s_cs}, 8'h22)
    rst_pulse(2);
    `CHK(lock, 1'b0)
    op(6'h01, fbd_pkg::LOCK_STAT, 32'h0, st, r);
    `CHK(r[7:0], 8'h01)
    $display("test lockout done");
  endtask : t_lock
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    rst_i = 1'b1;
    {cyc, we, adr, dat, fj, tj, mp, clr} = '0;
    rst_pulse(12);
    t_decode();
    t_gate();
    t_regs();
    t_lock();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    close_out();
  end
endmodule : fbd_tb_top
